// ==== hdl/opt_pkg.sv ====
// Constants and types for the output pulse test sequencer
package opt_pkg;
  // ==========================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int OOO_MIN_US = 1700;
  localparam int OOO_MAX_US = 20000;
  localparam int ONO_FIRST_US = 5000;
  localparam int ONO_RETRY_US = 7500;
  localparam int GAP_US = 5000;
  localparam int G32_US = 1000;
  localparam int OOO_MAX_PULSES = 7;
  localparam int ONO_MAX_PULSES = 2;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
  localparam logic [7:0] GAP_TK = 8'(GAP_US / TICK_US);
  localparam logic [7:0] G32_TK = 8'(G32_US / TICK_US);
  localparam logic [7:0] ONO1_TK = 8'(ONO_FIRST_US / TICK_US);
  localparam logic [7:0] ONO2_TK = 8'(ONO_RETRY_US / TICK_US);
  localparam logic [2:0] OOO_LAST = 3'(OOO_MAX_PULSES - 1);
  localparam logic [2:0] ONO_LAST = 3'(ONO_MAX_PULSES - 1);
  localparam int NPT = 16;
  // ==========================================
  // Register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_DFLT = 8'h08;
  localparam logic [7:0] A_VOTED = 8'h0C;
  localparam logic [7:0] A_ATEN = 8'h10;
  localparam logic [7:0] A_NLEN = 8'h14;
  localparam logic [7:0] A_OLEN = 8'h18;
  localparam logic [7:0] A_PASS = 8'h1C;
  localparam logic [7:0] A_ATF = 8'h20;
  localparam logic [7:0] A_OVL = 8'h24;
  localparam logic [7:0] A_NLD = 8'h28;
  localparam logic [7:0] A_CUR = 8'h2C;
  localparam logic [7:0] A_ISTAT = 8'h30;
  localparam logic [7:0] A_IEN = 8'h34;
  localparam logic [7:0] A_ICLR = 8'h38;
  localparam logic [7:0] A_STAT = 8'h3C;
  localparam logic [7:0] A_INDEP = 8'h40;
  localparam int CTRL_FLOG = 0;
  localparam int CTRL_FCLR = 1;
  localparam int CTRL_G32 = 2;
  localparam int STAT_ACC = 0;
  localparam int STAT_ST = 1;
  localparam int STAT_PT = 4;
  localparam int NEV = 4;
  // ==========================================
  // Types
  typedef struct packed {
    logic pwr;
    logic nld;
    logic ovl;
    logic atf;
  } opt_evt_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_PULSE = 2'h1,
    S_EVAL = 2'h3,
    S_GAP = 2'h2
  } opt_st_t;
  // Off-on-off ladder: pulse n of seven, evenly spread over the width range
  function automatic logic [7:0] ooo_width(input logic [2:0] n);
    int lo;
    int hi;
    lo = OOO_MIN_US / TICK_US;
    hi = OOO_MAX_US / TICK_US;
    return 8'(lo + int'(n) * (hi - lo) / (OOO_MAX_PULSES - 1));
  endfunction
endpackage

// ==== hdl/opt_seq.sv ====
// Output pulse test sequencer with APB registers
`timescale 1ns/1ns
module opt_seq (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] volt_fb,
  input wire logic [15:0] cur_fb,
  input wire logic [15:0] ovl_fb,
  input wire logic pwr_ok,
  output logic [15:0] drive,
  output logic irq
);
  // ==========================================
  // Pin synchronisers
  logic [48:0] s1_q;
  logic [48:0] s2_q;
  logic pwr_q;
  logic [15:0] volt_s;
  logic [15:0] cur_s;
  logic [15:0] ovl_s;
  logic pwr_s;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Power-good resets high so leaving reset is not taken as a power return
      s1_q <= {1'b1, 48'h000000000000};
      s2_q <= {1'b1, 48'h000000000000};
      pwr_q <= 1'b1;
    end else begin
      s1_q <= {pwr_ok, ovl_fb, cur_fb, volt_fb};
      s2_q <= s1_q;
      pwr_q <= s2_q[48];
    end
  end
  assign volt_s = s2_q[15:0];
  assign cur_s = s2_q[31:16];
  assign ovl_s = s2_q[47:32];
  assign pwr_s = s2_q[48];

  // ==========================================
  // Tick base
  logic [11:0] tc_q;
  logic [11:0] tc_d;
  logic tick;
  always_comb begin
    tick = (tc_q == opt_pkg::TICK_LAST);
    tc_d = tick ? '0 : tc_q + 12'h001;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tc_q <= '0;
    end else begin
      tc_q <= tc_d;
    end
  end

  // ==========================================
  // Registers and APB
  logic g32_q, g32_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] dflt_q, dflt_d;
  logic [15:0] voted_q, voted_d;
  logic [15:0] indep_q, indep_d;
  logic [15:0] at_q, at_d;
  logic [15:0] nl_q, nl_d;
  logic [15:0] ol_q, ol_d;
  logic [opt_pkg::NEV-1:0] ien_q, ien_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  logic wr;
  logic flog;
  logic fclr;
  logic [opt_pkg::NEV-1:0] iclr;
  logic hit;
  // Diagnostic state declared here for the read mux
  logic [15:0] pass_q, atf_q, ovl_q, nld_q, cur_q;
  logic [opt_pkg::NEV-1:0] ist_q;
  logic acc_q;
  opt_pkg::opt_st_t st_q;
  logic [3:0] pt_q;

  always_comb begin
    wr = psel && penable && pwrite && rdy_q && !err_q;
    flog = wr && (paddr == opt_pkg::A_CTRL) && pwdata[opt_pkg::CTRL_FLOG];
    fclr = wr && (paddr == opt_pkg::A_CTRL) && pwdata[opt_pkg::CTRL_FCLR];
    iclr = (wr && (paddr == opt_pkg::A_ICLR)) ? pwdata[opt_pkg::NEV-1:0] : '0;
    g32_d = g32_q;
    cmd_d = cmd_q;
    dflt_d = dflt_q;
    voted_d = voted_q;
    indep_d = indep_q & ~voted_q;
    at_d = at_q;
    nl_d = nl_q;
    ol_d = ol_q;
    ien_d = ien_q;
    if (wr) begin
      case (paddr)
        opt_pkg::A_CTRL: g32_d = pwdata[opt_pkg::CTRL_G32];
        opt_pkg::A_CMD: cmd_d = pwdata[15:0];
        opt_pkg::A_DFLT: dflt_d = pwdata[15:0];
        opt_pkg::A_VOTED: voted_d = pwdata[15:0];
        opt_pkg::A_INDEP: indep_d = pwdata[15:0] & ~voted_q;
        opt_pkg::A_ATEN: at_d = pwdata[15:0];
        opt_pkg::A_NLEN: nl_d = pwdata[15:0];
        opt_pkg::A_OLEN: ol_d = pwdata[15:0];
        opt_pkg::A_IEN: ien_d = pwdata[opt_pkg::NEV-1:0];
        default: ;
      endcase
    end
    hit = 1'b1;
    rd_d = '0;
    case (paddr)
      opt_pkg::A_CTRL: rd_d[opt_pkg::CTRL_G32] = g32_q;
      opt_pkg::A_CMD: rd_d[15:0] = cmd_q;
      opt_pkg::A_DFLT: rd_d[15:0] = dflt_q;
      opt_pkg::A_VOTED: rd_d[15:0] = voted_q;
      opt_pkg::A_INDEP: rd_d[15:0] = indep_q;
      opt_pkg::A_ATEN: rd_d[15:0] = at_q;
      opt_pkg::A_NLEN: rd_d[15:0] = nl_q;
      opt_pkg::A_OLEN: rd_d[15:0] = ol_q;
      opt_pkg::A_PASS: rd_d[15:0] = pass_q;
      opt_pkg::A_ATF: rd_d[15:0] = atf_q;
      opt_pkg::A_OVL: rd_d[15:0] = ovl_q;
      opt_pkg::A_NLD: rd_d[15:0] = nld_q;
      opt_pkg::A_CUR: rd_d[15:0] = cur_q;
      opt_pkg::A_ISTAT: rd_d[opt_pkg::NEV-1:0] = ist_q;
      opt_pkg::A_IEN: rd_d[opt_pkg::NEV-1:0] = ien_q;
      opt_pkg::A_ICLR: ;
      opt_pkg::A_STAT: begin
        rd_d[opt_pkg::STAT_ACC] = acc_q;
        rd_d[opt_pkg::STAT_ST+:2] = st_q;
        rd_d[opt_pkg::STAT_PT+:4] = pt_q;
      end
      default: hit = 1'b0;
    endcase
    // Setup cycle latches the answer so access phase needs no wait
    rdy_d = psel && !penable;
    err_d = psel && !penable && !hit;
    if (!(psel && !penable)) begin
      rd_d = rd_q;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      g32_q <= 1'b0;
      cmd_q <= '0;
      dflt_q <= '0;
      voted_q <= '0;
      indep_q <= '0;
      at_q <= '0;
      nl_q <= '0;
      ol_q <= '0;
      ien_q <= '0;
      rd_q <= '0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      g32_q <= g32_d;
      cmd_q <= cmd_d;
      dflt_q <= dflt_d;
      voted_q <= voted_d;
      indep_q <= indep_d;
      at_q <= at_d;
      nl_q <= nl_d;
      ol_q <= ol_d;
      ien_q <= ien_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = rdy_q && err_q;

  // ==========================================
  // Logon gate and applied outputs
  logic acc_d;
  logic [15:0] app_q, app_d;
  logic pwr_rise;
  always_comb begin
    pwr_rise = pwr_s && !pwr_q;
    acc_d = acc_q;
    if (pwr_rise) begin
      acc_d = 1'b0;
    end else if (flog || (cmd_q == dflt_q)) begin
      acc_d = 1'b1;
    end
    // Voted points follow the voted command only
    app_d = acc_q ? ((cmd_q & voted_q) | indep_q) : dflt_q;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc_q <= 1'b0;
      app_q <= '0;
    end else begin
      acc_q <= acc_d;
      app_q <= app_d;
    end
  end

  // ==========================================
  // Pulse test sequencer
  opt_pkg::opt_st_t st_d;
  logic [3:0] pt_d;
  logic [2:0] n_q, n_d;
  logic [7:0] tmr_q, tmr_d;
  logic ons_q, ons_d;
  logic fin_q, fin_d;
  logic vok_q, vok_d;
  logic cok_q, cok_d;
  logic ok;
  logic last;
  logic [15:0] pass_set, atf_set, nld_set, cur_set, cur_val, pt_oh;

  function automatic logic [7:0] pw(input logic on, input logic [2:0] n, input logic g);
    if (g) begin
      return opt_pkg::G32_TK;
    end else if (on) begin
      return (n == '0) ? opt_pkg::ONO1_TK : opt_pkg::ONO2_TK;
    end
    return opt_pkg::ooo_width(n);
  endfunction

  always_comb begin
    st_d = st_q;
    pt_d = pt_q;
    n_d = n_q;
    tmr_d = tmr_q;
    ons_d = ons_q;
    fin_d = fin_q;
    vok_d = vok_q;
    cok_d = cok_q;
    pass_set = '0;
    atf_set = '0;
    nld_set = '0;
    cur_set = '0;
    cur_val = '0;
    pt_oh = 16'h0001 << pt_q;
    // Off-on-off: volts and, if enabled, current; on-off-on: volts only
    ok = vok_q && (ons_q || !nl_q[pt_q] || cok_q);
    last = g32_q || (n_q == (ons_q ? opt_pkg::ONO_LAST : opt_pkg::OOO_LAST));
    case (st_q)
      opt_pkg::S_IDLE: begin
        if (at_q[pt_q] && voted_q[pt_q]) begin
          ons_d = app_q[pt_q];
          n_d = '0;
          fin_d = 1'b0;
          tmr_d = pw(app_q[pt_q], 3'h0, g32_q);
          st_d = opt_pkg::S_PULSE;
        end else begin
          pt_d = pt_q + 4'h1;
        end
      end
      opt_pkg::S_PULSE: begin
        if (!at_q[pt_q]) begin
          // Autotest withdrawn mid-test: restore at once and move on
          fin_d = 1'b1;
          pt_d = pt_q + 4'h1;
          tmr_d = opt_pkg::GAP_TK;
          st_d = opt_pkg::S_GAP;
        end else if (tick) begin
          if (tmr_q == 8'h01) begin
            vok_d = (volt_s[pt_q] == !ons_q);
            cok_d = cur_s[pt_q];
            if (!ons_q && nl_q[pt_q]) begin
              cur_set = pt_oh;
              cur_val = cur_s;
            end
            st_d = opt_pkg::S_EVAL;
          end else begin
            tmr_d = tmr_q - 8'h01;
          end
        end
      end
      opt_pkg::S_EVAL: begin
        tmr_d = opt_pkg::GAP_TK;
        st_d = opt_pkg::S_GAP;
        if (ok) begin
          pass_set = pt_oh;
          fin_d = 1'b1;
          pt_d = pt_q + 4'h1;
        end else if (last) begin
          atf_set = pt_oh;
          if (!ons_q && vok_q && nl_q[pt_q]) begin
            nld_set = pt_oh;
          end
          fin_d = 1'b1;
          pt_d = pt_q + 4'h1;
        end else begin
          n_d = n_q + 3'h1;
        end
      end
      opt_pkg::S_GAP: begin
        if (tick) begin
          if (tmr_q == 8'h01) begin
            tmr_d = pw(ons_q, n_q, g32_q);
            st_d = fin_q ? opt_pkg::S_IDLE : opt_pkg::S_PULSE;
          end else begin
            tmr_d = tmr_q - 8'h01;
          end
        end
      end
      default: st_d = opt_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= opt_pkg::S_IDLE;
      pt_q <= '0;
      n_q <= '0;
      tmr_q <= '0;
      ons_q <= 1'b0;
      fin_q <= 1'b0;
      vok_q <= 1'b0;
      cok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pt_q <= pt_d;
      n_q <= n_d;
      tmr_q <= tmr_d;
      ons_q <= ons_d;
      fin_q <= fin_d;
      vok_q <= vok_d;
      cok_q <= cok_d;
    end
  end

  // ==========================================
  // Drivers
  logic [15:0] drv_q, drv_d;
  always_comb begin
    drv_d = app_q;
    if (st_q == opt_pkg::S_PULSE) begin
      drv_d = app_q ^ pt_oh;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end
  assign drive = drv_q;

  // ==========================================
  // Diagnostics and interrupt
  logic [15:0] pass_d, atf_d, ovl_d, nld_d, cur_d, ovl_set, keep;
  logic [opt_pkg::NEV-1:0] ist_d;
  opt_pkg::opt_evt_t ev;
  always_comb begin
    // A set in the clearing cycle survives the clear
    keep = fclr ? '0 : 16'hFFFF;
    ovl_set = ovl_s & ol_q;
    pass_d = ((pass_q & ~atf_set) | pass_set) & (keep | pass_set);
    atf_d = ((atf_q & ~pass_set) & keep) | atf_set;
    ovl_d = (ovl_q & keep) | ovl_set;
    nld_d = (nld_q & keep) | nld_set;
    cur_d = (cur_q & ~cur_set) | (cur_val & cur_set);
    ev.atf = |atf_set;
    ev.ovl = |ovl_set;
    ev.nld = |nld_set;
    ev.pwr = pwr_rise;
    ist_d = (ist_q & ~iclr) | ev;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pass_q <= '0;
      atf_q <= '0;
      ovl_q <= '0;
      nld_q <= '0;
      cur_q <= '0;
      ist_q <= '0;
    end else begin
      pass_q <= pass_d;
      atf_q <= atf_d;
      ovl_q <= ovl_d;
      nld_q <= nld_d;
      cur_q <= cur_d;
      ist_q <= ist_d;
    end
  end
  assign irq = |(ist_q & ien_q);

  // ==========================================
  // Assertions
  property p_tick;
    @(posedge clock) disable iff (!nrst)
    tick |=> !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too close");

  property p_start;
    @(posedge clock) disable iff (!nrst)
    (st_q == opt_pkg::S_IDLE && st_d == opt_pkg::S_PULSE) |-> at_q[pt_q];
  endproperty
  a_start: assert property (p_start) else $error("pulse without autotest");

  property p_inv;
    @(posedge clock) disable iff (!nrst)
    (st_q == opt_pkg::S_PULSE) |=> (drive[$past(pt_q)] != $past(app_q[pt_q]));
  endproperty
  a_inv: assert property (p_inv) else $error("pulse not inverted");

  property p_ooo;
    @(posedge clock) disable iff (!nrst)
    !ons_q |-> (n_q <= opt_pkg::OOO_LAST);
  endproperty
  a_ooo: assert property (p_ooo) else $error("too many on pulses");

  property p_ono;
    @(posedge clock) disable iff (!nrst)
    (ons_q && st_q != opt_pkg::S_IDLE) |-> (n_q <= opt_pkg::ONO_LAST);
  endproperty
  a_ono: assert property (p_ono) else $error("too many off pulses");

  property p_gap;
    @(posedge clock) disable iff (!nrst)
    (st_q == opt_pkg::S_EVAL) |=> (st_q == opt_pkg::S_GAP) [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short");

  property p_eval;
    @(posedge clock) disable iff (!nrst)
    (st_q == opt_pkg::S_EVAL) |-> ($past(st_q) == opt_pkg::S_PULSE);
  endproperty
  a_eval: assert property (p_eval) else $error("eval without pulse");

  property p_ovl;
    @(posedge clock) disable iff (!nrst)
    (ovl_set != '0) |=> ((ovl_q & $past(ovl_set)) == $past(ovl_set));
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload lost");

  property p_clr;
    @(posedge clock) disable iff (!nrst)
    fclr |=> ((atf_q & ~$past(atf_set)) == '0);
  endproperty
  a_clr: assert property (p_clr) else $error("fault table not cleared");

  property p_logon;
    @(posedge clock) disable iff (!nrst)
    pwr_rise |=> !acc_q ##1 (app_q == $past(dflt_q));
  endproperty
  a_logon: assert property (p_logon) else $error("data taken before logon");

  property p_voted;
    @(posedge clock) disable iff (!nrst)
    ##1 ((indep_q & $past(voted_q)) == '0);
  endproperty
  a_voted: assert property (p_voted) else $error("voted point independent");
endmodule

// ==== testbench/opt_field.sv ====
// Field driver and feedback model at the far side of the sequencer
`timescale 1ns/1ns
module opt_field (
  input wire logic clock,
  input wire logic [15:0] drive,
  input wire logic [15:0] load_on,
  input wire logic [15:0] volt_stuck,
  input wire logic [15:0] surge,
  output logic [15:0] volt_fb = 16'h0000,
  output logic [15:0] cur_fb = 16'h0000,
  output logic [15:0] ovl_fb = 16'h0000
);
  // ==========================================
  // Feedback
  // Sense lines lag the drive by one clock, as real driver feedback does
  always @(posedge clock) begin
    volt_fb <= drive | volt_stuck;
    cur_fb <= drive & load_on;
    ovl_fb <= drive & surge;
  end
endmodule

// ==== testbench/tb_opt_seq.sv ====
// Self-checking bench for the output pulse test sequencer
`timescale 1ns/1ns
module tb_opt_seq;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } opt_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] volt_fb;
  logic [15:0] cur_fb;
  logic [15:0] ovl_fb;
  logic pwr_ok = 1'b1;
  logic [15:0] drive;
  logic irq;
  logic [15:0] load_on = 16'hFFFF;
  logic [15:0] volt_stuck = 16'h0000;
  logic [15:0] surge = 16'h0000;
  logic [31:0] rd;
  logic er;
  logic p1_seen = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  opt_row_t rows [12];
  opt_seq opt_seq_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .volt_fb(volt_fb), .cur_fb(cur_fb), .ovl_fb(ovl_fb),
    .pwr_ok(pwr_ok), .drive(drive), .irq(irq));
  opt_field opt_field_inst (.clock(clock), .drive(drive), .load_on(load_on),
    .volt_stuck(volt_stuck), .surge(surge), .volt_fb(volt_fb), .cur_fb(cur_fb),
    .ovl_fb(ovl_fb));
  // ==========================================
  // Clock, watchdog and helpers
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (drive[1] === 1'b1) p1_seen <= 1'b1;
    if (cyc == 90000) begin
      fail_count++;
      $display("FAIL %0t run took too long", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      $display("FAIL %0t %s", $time, msg);
      fail_count++;
    end
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
  endtask
  // Holds the request until pready is seen, then takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string msg);
    apb(1'b0, a, 32'h00000000);
    check(rd === e, msg);
  endtask
  task automatic wait_drv(input int i, input logic v, input int lim);
    n = 0;
    while (drive[i] !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    check(n < lim, "drive did not change");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rows[0] = {1'b0, opt_pkg::A_CMD, 32'h0, 32'h0, 1'b0};
    rows[1] = {1'b0, opt_pkg::A_ISTAT, 32'h0, 32'h0, 1'b0};
    rows[2] = {1'b1, opt_pkg::A_VOTED, 32'hFFFF00FF, 32'h000000FF, 1'b0};
    rows[3] = {1'b1, opt_pkg::A_INDEP, 32'h0000FFFF, 32'h0000FF00, 1'b0};
    rows[4] = {1'b1, opt_pkg::A_CMD, 32'hFFFFFFFF, 32'h0000FFFF, 1'b0};
    rows[5] = {1'b1, opt_pkg::A_CTRL, 32'h00000007, 32'h00000004, 1'b0};
    rows[6] = {1'b1, opt_pkg::A_CTRL, 32'h00000000, 32'h00000000, 1'b0};
    rows[7] = {1'b1, opt_pkg::A_PASS, 32'h0000FFFF, 32'h00000000, 1'b0};
    rows[8] = {1'b1, opt_pkg::A_ICLR, 32'h0000000F, 32'h00000000, 1'b0};
    rows[9] = {1'b1, opt_pkg::A_NLEN, 32'h0000FFFF, 32'h0000FFFF, 1'b0};
    rows[10] = {1'b1, opt_pkg::A_OLEN, 32'h0000FFFF, 32'h0000FFFF, 1'b0};
    rows[11] = {1'b0, 8'h44, 32'h0, 32'h0, 1'b1};
    do_reset();
    check(drive === 16'h0000 && irq === 1'b0, "reset outputs");
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd === rows[i].e && er === rows[i].err, "register row");
    end
    $display("register table done");
    // Power return, logon, interrupts, overload and fault clear
    do_reset();
    apb(1'b1, opt_pkg::A_VOTED, 32'h00000003);
    apb(1'b1, opt_pkg::A_CMD, 32'h00000003);
    pwr_ok <= 1'b0;
    repeat (4) @(posedge clock);
    pwr_ok <= 1'b1;
    repeat (6) @(posedge clock);
    check(drive === 16'h0000, "defaults held after power return");
    check(irq === 1'b0, "masked event raised irq");
    rdchk(opt_pkg::A_ISTAT, 32'h00000008, "power event status");
    apb(1'b1, opt_pkg::A_IEN, 32'h0000000A);
    // A write lands at the access edge, so its effect is seen one edge later
    @(posedge clock);
    check(irq === 1'b1, "enabled event gave no irq");
    apb(1'b1, opt_pkg::A_ICLR, 32'h00000008);
    @(posedge clock);
    check(irq === 1'b0, "irq after clear");
    apb(1'b1, opt_pkg::A_CTRL, 32'h00000001);
    repeat (3) @(posedge clock);
    check(drive === 16'h0003, "outputs after force logon");
    // Point field is the free-running scan position while no point is tested
    apb(1'b0, opt_pkg::A_STAT, 32'h00000000);
    check(rd[31:8] === 24'h000000 && rd[3:0] === 4'h1, "logon status");
    apb(1'b1, opt_pkg::A_OLEN, 32'h00000001);
    surge <= 16'h0001;
    repeat (6) @(posedge clock);
    surge <= 16'h0000;
    repeat (6) @(posedge clock);
    rdchk(opt_pkg::A_OVL, 32'h00000001, "overload not recorded");
    check(irq === 1'b1, "overload irq");
    apb(1'b1, opt_pkg::A_CTRL, 32'h00000002);
    rdchk(opt_pkg::A_OVL, 32'h00000000, "fault table not cleared");
    $display("logon and faults done");
    // Off-on-off on an off point, neighbour without autotest
    do_reset();
    p1_seen <= 1'b0;
    apb(1'b1, opt_pkg::A_VOTED, 32'h00000003);
    apb(1'b1, opt_pkg::A_NLEN, 32'h00000001);
    apb(1'b1, opt_pkg::A_ATEN, 32'h00000001);
    wait_drv(0, 1'b1, 6000);
    wait_drv(0, 1'b0, 60000);
    check(n > 16 * 2500 && n <= 17 * 2500 + 4, "first on pulse width");
    repeat (8) @(posedge clock);
    check(p1_seen === 1'b0, "point without autotest pulsed");
    rdchk(opt_pkg::A_CUR, 32'h00000001, "current sample");
    rdchk(opt_pkg::A_PASS, 32'h00000001, "pass flag");
    rdchk(opt_pkg::A_ATF, 32'h00000000, "fail flag");
    rdchk(opt_pkg::A_STAT, 32'h00000015, "gap state after pass");
    $display("off-on-off done");
    // Short on-off-on in 32-circuit mode with volts stuck high
    do_reset();
    load_on <= 16'h0000;
    volt_stuck <= 16'h0001;
    apb(1'b1, opt_pkg::A_CTRL, 32'h00000004);
    apb(1'b1, opt_pkg::A_VOTED, 32'h00000001);
    apb(1'b1, opt_pkg::A_CMD, 32'h00000001);
    apb(1'b1, opt_pkg::A_NLEN, 32'h00000001);
    apb(1'b1, opt_pkg::A_IEN, 32'h00000001);
    apb(1'b1, opt_pkg::A_ATEN, 32'h00000001);
    wait_drv(0, 1'b0, 6000);
    wait_drv(0, 1'b1, 30000);
    check(n > 9 * 2500 && n <= 10 * 2500 + 4, "short off pulse width");
    repeat (8) @(posedge clock);
    rdchk(opt_pkg::A_ATF, 32'h00000001, "stuck volts not failed");
    rdchk(opt_pkg::A_NLD, 32'h00000000, "no-load judged on on-off-on");
    check(irq === 1'b1, "autotest fail irq");
    $display("on-off-on done");
    end_sim();
  end
endmodule
